// File: hw/uart_timer_port.v
/*
 * Full-duplex serial port, 8-bit and 9-bit framing, bit clock from
 * an 8-bit auto-reload timer, transmit FIFO, one-byte receive buffer.
 * Assumes a plain register port and serial input synchronous to clock.
 */
`include "uart_consts.vh"
`default_nettype none

module uart_timer_port #(
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW    = 3
) (
	input  wire       I_SYS_CLK,
	input  wire       I_RST_B,
	input  wire [2:0] I_ADDR,
	input  wire [7:0] I_WDATA,
	input  wire       I_WR,
	input  wire       I_RD,
	output reg  [7:0] O_RDATA,
	output wire       O_TX_READY,
	input  wire       I_SERIAL_IN_PIN,
	output reg        O_SERIAL_OUT_PIN,
	input  wire       I_EXT_OSC,
	input  wire       I_TIMER_INPUT_PIN,
	input  wire       I_INT_ENABLE,
	output wire       O_IRQ
);

	localparam TX_IDLE  = 2'h0;
	localparam TX_FETCH = 2'h1;
	localparam TX_WAIT  = 2'h2;
	localparam TX_SHIFT = 2'h3;
	localparam RX_IDLE  = 2'h0;
	localparam RX_START = 2'h1;
	localparam RX_BITS  = 2'h2;

	reg  [7:0]  serial_control;
	reg  [7:0]  timer_control;
	reg  [7:0]  timer_one_reload;
	reg  [7:0]  rx_buffer;
	reg  [1:0]  tx_state;
	reg  [10:0] tx_shift;
	reg  [3:0]  tx_left;
	reg         tx_div;
	reg         tx_set_ti;
	reg  [1:0]  rx_state;
	reg  [9:0]  rx_shift;
	reg  [3:0]  rx_left;
	reg         rx_phase;
	reg         rx_prev;
	reg         rx_set_ri;
	reg         rx_store;
	reg  [9:0]  rx_full;
	reg  [7:0]  rx_data;
	reg         rx_ninth;
	reg         rx_check;
	reg  [7:0]  next_rdata;
	wire        tx_ovf;
	wire        rx_ovf;
	wire [7:0]  timer_one_low_count;
	wire        fifo_valid;
	wire [7:0]  fifo_data;
	wire        mode9 = serial_control[`SC_MODE9];
	wire        wr_data = I_WR && (I_ADDR == `OFS_SERIAL_DATA_BUFFER);
	wire        wr_ctl  = I_WR && (I_ADDR == `OFS_SERIAL_CONTROL);
	wire        tx_pop  = (tx_state == TX_IDLE) && fifo_valid;
	wire        tx_bit  = tx_ovf && tx_div;
	wire        rx_start_edge = (rx_state == RX_IDLE) && serial_control[`SC_REN] && rx_prev && !I_SERIAL_IN_PIN;

	assign O_IRQ = I_INT_ENABLE && (serial_control[`SC_TI] || serial_control[`SC_RI]);

	// ==================================================
	// Transmit FIFO
	// data location write loads transmitter
	uart_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_tx_fifo (
		.i_clk       (I_SYS_CLK),
		.i_rst_b     (I_RST_B),
		.i_in_valid  (wr_data),
		.o_in_ready  (O_TX_READY),
		.i_in_data   (I_WDATA),
		.o_out_valid (fifo_valid),
		.i_out_ready (tx_pop),
		.o_out_data  (fifo_data)
	);

	// ==================================================
	// Bit clock timers
	// six clock sources, 256 minus reload
	uart_baud_timer u_baud (
		.i_clk       (I_SYS_CLK),
		.i_rst_b     (I_RST_B),
		.i_enable    (timer_control[`TC_ENABLE]),
		.i_sel       (timer_control[`TC_SEL_HI:`TC_SEL_LO]),
		.i_reload    (timer_one_reload),
		.i_ext_osc   (I_EXT_OSC),
		.i_timer_pin (I_TIMER_INPUT_PIN),
		.i_rx_reload (rx_start_edge),
		.o_tx_ovf    (tx_ovf),
		.o_rx_ovf    (rx_ovf),
		.o_tx_count  (timer_one_low_count)
	);

	// ==================================================
	// Register writes and flags
	always @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			serial_control   <= `SC_RESET;
			timer_control    <= `TC_RESET;
			timer_one_reload <= `RELOAD_RESET;
		end
		else
		begin
			if (wr_ctl)
				serial_control <= {I_WDATA[7], 1'b1, I_WDATA[5:0]};
			if (I_WR && (I_ADDR == `OFS_TIMER_CONTROL))
				timer_control <= {4'h0, I_WDATA[3:0]};
			if (I_WR && (I_ADDR == `OFS_TIMER_ONE_RELOAD))
				timer_one_reload <= I_WDATA;
			// only software clears; hardware set wins
			if (tx_set_ti)
				serial_control[`SC_TI] <= 1'b1;
			if (rx_set_ri)
				serial_control[`SC_RI] <= 1'b1;
			if (rx_store)
				serial_control[`SC_RB8] <= mode9 ? rx_shift[8] : rx_shift[9];
		end
	end

	// ==================================================
	// Register reads, data one cycle later
	always @*
	begin
		case (I_ADDR)
			`OFS_SERIAL_CONTROL:      next_rdata = serial_control;
			`OFS_SERIAL_DATA_BUFFER:  next_rdata = rx_buffer;
			`OFS_TIMER_ONE_RELOAD:    next_rdata = timer_one_reload;
			`OFS_TIMER_CONTROL:       next_rdata = timer_control;
			`OFS_TIMER_ONE_LOW_COUNT: next_rdata = timer_one_low_count;
			default:                  next_rdata = 8'h00;
		endcase
	end

	always @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			O_RDATA <= 8'h00;
		else
			O_RDATA <= I_RD ? next_rdata : 8'h00;
	end

	// ==================================================
	// Transmitter
	always @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			tx_state         <= TX_IDLE;
			tx_shift         <= 11'h7ff;
			tx_left          <= 4'h0;
			tx_div           <= 1'b0;
			tx_set_ti        <= 1'b0;
			O_SERIAL_OUT_PIN <= 1'b1;
		end
		else
		begin
			tx_set_ti <= 1'b0;
			if (tx_ovf)
				tx_div <= ~tx_div;
			case (tx_state)
				TX_IDLE:
				begin
					if (fifo_valid)
						tx_state <= TX_FETCH;
				end
				TX_FETCH:
				begin
					if (mode9)
					begin
						tx_shift <= {1'b1, serial_control[`SC_TB8], fifo_data, 1'b0};
						tx_left  <= 4'hb;
					end
					else
					begin
						tx_shift <= {2'h3, fifo_data, 1'b0};
						tx_left  <= 4'ha;
					end
					tx_state <= TX_WAIT;
				end
				TX_WAIT:
				begin
					if (tx_bit)
					begin
						O_SERIAL_OUT_PIN <= tx_shift[0];
						tx_shift         <= {1'b1, tx_shift[10:1]};
						tx_left          <= tx_left - 4'h1;
						tx_state         <= TX_SHIFT;
					end
				end
				TX_SHIFT:
				begin
					if (tx_bit)
					begin
						if (tx_left == 4'h0)
						begin
							O_SERIAL_OUT_PIN <= 1'b1;
							tx_state         <= TX_IDLE;
						end
						else
						begin
							O_SERIAL_OUT_PIN <= tx_shift[0];
							tx_shift         <= {1'b1, tx_shift[10:1]};
							tx_left          <= tx_left - 4'h1;
							// done flag as stop bit begins
							if (tx_left == 4'h1)
								tx_set_ti <= 1'b1;
						end
					end
				end
				default:
					tx_state <= TX_IDLE;
			endcase
		end
	end

	// ==================================================
	// Receive frame decode
	always @*
	begin
		rx_full = {I_SERIAL_IN_PIN, rx_shift[9:1]};
		if (mode9)
		begin
			rx_data  = rx_full[7:0];
			rx_ninth = rx_full[8];
		end
		else
		begin
			rx_data  = rx_full[8:1];
			rx_ninth = rx_full[9];
		end
		// flag clear, check bit when enabled
		rx_check = !serial_control[`SC_RI] && (!serial_control[`SC_MCE] || rx_ninth);
	end

	// ==================================================
	// Receiver
	always @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			rx_state  <= RX_IDLE;
			rx_shift  <= 10'h000;
			rx_left   <= 4'h0;
			rx_phase  <= 1'b0;
			rx_prev   <= 1'b1;
			rx_set_ri <= 1'b0;
			rx_store  <= 1'b0;
			rx_buffer <= 8'h00;
		end
		else
		begin
			rx_prev   <= I_SERIAL_IN_PIN;
			rx_set_ri <= 1'b0;
			rx_store  <= 1'b0;
			case (rx_state)
				RX_IDLE:
				begin
					if (rx_start_edge)
						rx_state <= RX_START;
				end
				RX_START:
				begin
					if (rx_ovf)
					begin
						rx_phase <= 1'b0;
						rx_left  <= mode9 ? 4'ha : 4'h9;
						rx_state <= I_SERIAL_IN_PIN ? RX_IDLE : RX_BITS;
					end
				end
				RX_BITS:
				begin
					if (rx_ovf)
					begin
						rx_phase <= ~rx_phase;
						if (rx_phase)
						begin
							rx_shift <= rx_full;
							rx_left  <= rx_left - 4'h1;
							if (rx_left == 4'h1)
							begin
								rx_state <= RX_IDLE;
								if (rx_check)
								begin
									rx_buffer <= rx_data;
									rx_store  <= 1'b1;
									rx_set_ri <= 1'b1;
								end
							end
						end
					end
				end
				default:
					rx_state <= RX_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// File: include/uart_consts.vh
/*
 * Constants of the serial port with timer-driven bit clock:
 * register offsets, field positions, reset values, clock selects.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH

// ==================================================
// Register offsets
`define OFS_SERIAL_CONTROL      3'h0
`define OFS_SERIAL_DATA_BUFFER  3'h1
`define OFS_TIMER_ONE_RELOAD    3'h2
`define OFS_TIMER_CONTROL       3'h3
`define OFS_TIMER_ONE_LOW_COUNT 3'h4

// ==================================================
// serial_control fields
`define SC_MODE9      7
`define SC_ONE        6
`define SC_MCE        5
`define SC_REN        4
`define SC_TB8        3
`define SC_RB8        2
`define SC_TI         1
`define SC_RI         0
`define SC_RESET      8'h40

// ==================================================
// timer_control fields
`define TC_ENABLE     0
`define TC_SEL_LO     1
`define TC_SEL_HI     3
`define TC_RESET      8'h00
`define RELOAD_RESET  8'h00

// ==================================================
// Timer clock selects and prescale
`define SEL_CORE      3'h0
`define SEL_DIV4      3'h1
`define SEL_DIV12     3'h2
`define SEL_DIV48     3'h3
`define SEL_EXTOSC8   3'h4
`define SEL_PIN       3'h5
`define PRE_LAST      6'h2f
`define EXT_DIV_LAST  3'h7
`define COUNT_TOP     8'hff

`endif

// File: hw/uart_fifo.v
/*
 * Small synchronous FIFO with registered read data.
 * Assumes one clock; data appear the cycle after a pop.
 */
`default_nettype none

module uart_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             i_clk,
	input  wire             i_rst_b,
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output reg  [WIDTH-1:0] o_out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      fill;

	wire push = i_in_valid && o_in_ready;
	wire pop  = i_out_ready && o_out_valid;

	assign o_in_ready  = (fill != DEPTH[AW:0]);
	assign o_out_valid = (fill != {(AW+1){1'b0}});

	// ==================================================
	// Storage
	always @(posedge i_clk)
	begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	// ==================================================
	// Pointers and fill level
	always @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wr_ptr     <= {AW{1'b0}};
			rd_ptr     <= {AW{1'b0}};
			fill       <= {(AW+1){1'b0}};
			o_out_data <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
			begin
				rd_ptr     <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
				o_out_data <= mem[rd_ptr];
			end
			if (push && !pop)
				fill <= fill + 1'b1;
			else if (pop && !push)
				fill <= fill - 1'b1;
		end
	end

endmodule

`default_nettype wire

// File: hw/uart_baud_timer.v
/*
 * Reload timer and hidden receive copy making bit-clock overflows.
 * Assumes ext oscillator and timer pin inputs synchronous to i_clk.
 */
`include "uart_consts.vh"
`default_nettype none

module uart_baud_timer (
	input  wire       i_clk,
	input  wire       i_rst_b,
	input  wire       i_enable,
	input  wire [2:0] i_sel,
	input  wire [7:0] i_reload,
	input  wire       i_ext_osc,
	input  wire       i_timer_pin,
	input  wire       i_rx_reload,
	output reg        o_tx_ovf,
	output reg        o_rx_ovf,
	output reg  [7:0] o_tx_count
);

	reg [5:0] pre;
	reg [2:0] ext_div;
	reg       ext_prev;
	reg       pin_prev;
	reg [7:0] rx_count;
	reg       tick;

	// ==================================================
	// Timer clock source select
	always @*
	begin
		case (i_sel)
			`SEL_CORE:    tick = 1'b1;
			`SEL_DIV4:    tick = (pre[1:0] == 2'h3);
			`SEL_DIV12:   tick = (pre == 6'h0b) || (pre == 6'h17) || (pre == 6'h23) || (pre == `PRE_LAST);
			`SEL_DIV48:   tick = (pre == `PRE_LAST);
			`SEL_EXTOSC8: tick = i_ext_osc && !ext_prev && (ext_div == `EXT_DIV_LAST);
			`SEL_PIN:     tick = i_timer_pin && !pin_prev;
			default:      tick = 1'b0;
		endcase
	end

	always @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			pre        <= 6'h00;
			ext_div    <= 3'h0;
			ext_prev   <= 1'b0;
			pin_prev   <= 1'b0;
			o_tx_count <= 8'h00;
			rx_count   <= 8'h00;
			o_tx_ovf   <= 1'b0;
			o_rx_ovf   <= 1'b0;
		end
		else
		begin
			pre      <= (pre == `PRE_LAST) ? 6'h00 : pre + 6'h01;
			ext_prev <= i_ext_osc;
			pin_prev <= i_timer_pin;
			if (i_ext_osc && !ext_prev)
				ext_div <= ext_div + 3'h1;
			o_tx_ovf <= 1'b0;
			o_rx_ovf <= 1'b0;
			if (i_enable && tick)
			begin
				if (o_tx_count == `COUNT_TOP)
				begin
					o_tx_count <= i_reload;
					o_tx_ovf   <= 1'b1;
				end
				else
					o_tx_count <= o_tx_count + 8'h01;
			end
			if (i_rx_reload)
				rx_count <= i_reload;
			else if (i_enable && tick)
			begin
				if (rx_count == `COUNT_TOP)
				begin
					rx_count <= i_reload;
					o_rx_ovf <= 1'b1;
				end
				else
					rx_count <= rx_count + 8'h01;
			end
		end
	end

endmodule

`default_nettype wire

// File: bench/uart_timer_port_props.sv
/* Checker of register-port and serial-line timing of the serial port.
   Sees only the top-level ports; bound from the bench top file. */
`default_nettype none

module uart_timer_port_props (
	input wire logic       I_SYS_CLK,
	input wire logic       I_RST_B,
	input wire logic [2:0] I_ADDR,
	input wire logic       I_WR,
	input wire logic       I_RD,
	input wire logic [7:0] O_RDATA,
	input wire logic       O_TX_READY,
	input wire logic       O_SERIAL_OUT_PIN,
	input wire logic       I_INT_ENABLE,
	input wire logic       O_IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_B);

	// ==========
	// Register port
	property p_rdata_idle; !$past(I_RD) |-> O_RDATA == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
	property p_unmapped; I_RD && I_ADDR > 3'h4 |=> O_RDATA == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ctrl_one; I_RD && I_ADDR == 3'h0 |=> O_RDATA[6]; endproperty
	a_ctrl_one: assert property (p_ctrl_one) else $error("control bit 6 not one");
	property p_fifo_full; $fell(O_TX_READY) |-> $past(I_WR) && $past(I_ADDR) == 3'h1; endproperty
	a_fifo_full: assert property (p_fifo_full) else $error("ready fell without data write");

	// ==========
	// Interrupt
	property p_irq_gate; !I_INT_ENABLE |-> !O_IRQ; endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
	property p_irq_fall; $fell(O_IRQ) |-> $fell(I_INT_ENABLE) || ($past(I_WR) && $past(I_ADDR) == 3'h0);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("flag cleared without software");

	// ==========
	// Serial line
	property p_tx_low; $fell(O_SERIAL_OUT_PIN) |-> !O_SERIAL_OUT_PIN [*2]; endproperty
	a_tx_low: assert property (p_tx_low) else $error("low bit shorter than two cycles");
	property p_tx_high; $rose(O_SERIAL_OUT_PIN) |-> O_SERIAL_OUT_PIN [*2]; endproperty
	a_tx_high: assert property (p_tx_high) else $error("high bit shorter than two cycles");

	c_full: cover property ($fell(O_TX_READY));
	c_irq: cover property ($rose(O_IRQ));
	c_frame: cover property ($fell(O_SERIAL_OUT_PIN));
endmodule

`default_nettype wire

// File: bench/serial_peer.sv
/* Remote serial transceiver facing the port's line pins.
   Assumes idle-high line and a bit time given in clock cycles. */
`default_nettype none

module serial_peer (
	input  wire logic i_clk,
	input  wire logic i_line,
	input  wire logic i_nine,
	input  var  int   i_cyc,
	output var  logic o_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] got[$];
	logic [9:0] w;

	initial o_line = 1'b1;

	// ==========
	// Sender
	// frame layout
	task automatic send(input logic [8:0] d, input logic stop);
		o_line <= 1'b0;
		repeat (i_cyc) @(posedge i_clk);
		for (int k = 0; k < (i_nine ? 9 : 8); k++)
		begin
			o_line <= d[k];
			repeat (i_cyc) @(posedge i_clk);
		end
		o_line <= stop;
		repeat (i_cyc) @(posedge i_clk);
		o_line <= 1'b1;
	endtask

	// ==========
	// Receiver, mid-bit sampling
	// frame layout
	initial forever
	begin
		@(negedge i_line);
		w = 10'h3ff;
		repeat (i_cyc / 2) @(posedge i_clk);
		for (int k = 0; k <= (i_nine ? 9 : 8); k++)
		begin
			repeat (i_cyc) @(posedge i_clk);
			w[k] = i_line;
		end
		got.push_back(w);
	end
endmodule

`default_nettype wire

// File: bench/tb.sv
/* Bench of the timer-clocked serial port: registers, rates, FIFO, framing.
   Assumes the peer model and checker are compiled before it. */
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic            I_SYS_CLK, I_RST_B, I_WR, I_RD, I_EXT_OSC, I_TIMER_INPUT_PIN, I_INT_ENABLE, nine;
	logic [2:0]      I_ADDR;
	logic [7:0]      I_WDATA;
	wire logic [7:0] O_RDATA;
	wire logic       O_TX_READY, O_SERIAL_OUT_PIN, O_IRQ, rx_line;
	int              cyc, n, ticks, n_mismatch, total_checks;
	int              pre[6] = '{1, 4, 12, 48, 16, 2};

	uart_timer_port i_dut (.I_SYS_CLK, .I_RST_B, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_TX_READY,
		.I_SERIAL_IN_PIN(rx_line), .O_SERIAL_OUT_PIN, .I_EXT_OSC, .I_TIMER_INPUT_PIN, .I_INT_ENABLE, .O_IRQ);
	serial_peer i_peer (.i_clk(I_SYS_CLK), .i_line(O_SERIAL_OUT_PIN), .i_nine(nine), .i_cyc(cyc),
		.o_line(rx_line));

	// ==========
	// Clock, slow sources, timeout
	initial
	begin
		I_SYS_CLK = 1'b0;
		forever #4 I_SYS_CLK = ~I_SYS_CLK;
	end
	always @(posedge I_SYS_CLK)
	begin
		I_EXT_OSC <= ~I_EXT_OSC;
		I_TIMER_INPUT_PIN <= ~I_TIMER_INPUT_PIN;
		ticks++;
		if (ticks == 20000)
		begin
			n_mismatch++;
			finish_test();
		end
	end

	// ==========
	// Bus and compare helpers
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_SYS_CLK);
		I_WR <= 1'b0;
		@(posedge I_SYS_CLK);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_SYS_CLK);
		I_RD <= 1'b0;
		#1;
		check({2'b00, O_RDATA}, {2'b00, e});
		@(posedge I_SYS_CLK);
	endtask
	task automatic wait_got(input int k);
		for (n = 0; i_peer.got.size() < k && n < 3000; n++) @(posedge I_SYS_CLK);
		if (n == 3000)
			n_mismatch++;
	endtask

	// ==========
	// Scenarios
	task automatic t_reset();
		rd(3'h0, 8'h40);
		rd(3'h2, 8'h00);
		rd(3'h3, 8'h00);
		rd(3'h4, 8'h00);
		wr(3'h7, 8'hff);
		rd(3'h7, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_rates();
		wr(3'h2, 8'hff);
		wr(3'h0, 8'h10);
		for (int s = 0; s < 6; s++)
		begin
			cyc = 2 * pre[s];
			wr(3'h3, {4'h0, s[2:0], 1'b1});
			wr(3'h1, 8'h00);
			for (n = 0; O_SERIAL_OUT_PIN !== 1'b0 && n < 3000; n++) @(posedge I_SYS_CLK);
			for (n = 0; O_SERIAL_OUT_PIN === 1'b0 && n < 3000; n++) @(posedge I_SYS_CLK);
			check(10'(n), 10'(9 * cyc));
			wait_got(1);
			check(i_peer.got.pop_front(), {2'b11, 8'h00});
			repeat (2 * cyc) @(posedge I_SYS_CLK);
		end
		$display("t_rates done");
	endtask
	task automatic t_tx();
		I_INT_ENABLE <= 1'b0;
		repeat (2) @(posedge I_SYS_CLK);
		check(10'(O_IRQ), 10'h000);
		I_INT_ENABLE <= 1'b1;
		cyc = 8;
		// overflow at twice the bit rate
		wr(3'h2, 8'hfc);
		wr(3'h3, 8'h01);
		check(10'(O_IRQ), 10'h001);
		wr(3'h0, 8'h10);
		check(10'(O_IRQ), 10'h000);
		wr(3'h1, 8'ha5);
		for (n = 0; O_SERIAL_OUT_PIN !== 1'b0 && n < 500; n++) @(posedge I_SYS_CLK);
		for (n = 0; O_IRQ !== 1'b1 && n < 500; n++) @(posedge I_SYS_CLK);
		check(10'(n), 10'd73);
		wait_got(1);
		check(i_peer.got.pop_front(), {2'b11, 8'ha5});
		nine <= 1'b1;
		wr(3'h0, 8'h98);
		wr(3'h1, 8'h3c);
		wait_got(1);
		check(i_peer.got.pop_front(), {2'b11, 8'h3c});
		rd(3'h0, 8'hda);
		nine <= 1'b0;
		$display("t_tx done");
	endtask
	task automatic t_fifo();
		wr(3'h0, 8'h10);
		for (n = 0; O_TX_READY === 1'b1 && n < 12; n++) wr(3'h1, n[7:0]);
		check(10'(n), 10'd9);
		wr(3'h1, 8'hee);
		wait_got(9);
		for (int k = 0; k < 9; k++) check(i_peer.got.pop_front(), {2'b11, k[7:0]});
		repeat (200) @(posedge I_SYS_CLK);
		check(10'(i_peer.got.size()), 10'd0);
		$display("t_fifo done");
	endtask
	task automatic t_rx();
		wr(3'h0, 8'h10);
		fork
			i_peer.send(9'h05a, 1'b1);
			wr(3'h1, 8'hc3);
		join
		wait_got(1);
		check(i_peer.got.pop_front(), {2'b11, 8'hc3});
		rd(3'h0, 8'h57);
		rd(3'h1, 8'h5a);
		i_peer.send(9'h011, 1'b1);
		rd(3'h1, 8'h5a);
		wr(3'h0, 8'h30);
		i_peer.send(9'h022, 1'b0);
		rd(3'h0, 8'h70);
		wr(3'h0, 8'h10);
		i_peer.send(9'h033, 1'b0);
		rd(3'h0, 8'h51);
		rd(3'h1, 8'h33);
		nine <= 1'b1;
		wr(3'h0, 8'h90);
		i_peer.send(9'h066, 1'b1);
		rd(3'h0, 8'hd1);
		rd(3'h1, 8'h66);
		wr(3'h0, 8'hb0);
		i_peer.send(9'h044, 1'b1);
		rd(3'h0, 8'hf0);
		i_peer.send(9'h155, 1'b1);
		rd(3'h0, 8'hf5);
		rd(3'h1, 8'h55);
		$display("t_rx done");
	endtask

	// ==========
	// Main sequence and verdict
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		{I_RST_B, I_WR, I_RD, I_EXT_OSC, I_TIMER_INPUT_PIN, nine} = '0;
		I_INT_ENABLE = 1'b1;
		I_ADDR = 3'h0;
		I_WDATA = 8'h00;
		cyc = 8;
		repeat (2) @(posedge I_SYS_CLK);
		I_RST_B <= 1'b1;
		@(posedge I_SYS_CLK);
		t_reset();
		t_rates();
		t_tx();
		t_fifo();
		t_rx();
		finish_test();
	end
endmodule

bind uart_timer_port uart_timer_port_props i_props (.I_SYS_CLK, .I_RST_B, .I_ADDR, .I_WR, .I_RD, .O_RDATA,
	.O_TX_READY, .O_SERIAL_OUT_PIN, .I_INT_ENABLE, .O_IRQ);

`default_nettype wire
